// [core/bmcr_pkg.sv]
package bmcr_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] A_BAL_CTRL = 8'h32;
   localparam logic [7:0] A_BAL_TMO  = 8'h33;
   localparam logic [7:0] A_CONVERSION_TRIGGER     = 8'h34;
   localparam logic [7:0] A_SHADOW_KEY     = 8'h3a;
   localparam logic [7:0] A_NODE     = 8'h3b;
   localparam logic [7:0] A_RSTKEY   = 8'h3c;
   localparam logic [7:0] A_DBGKEY   = 8'h3d;
   localparam logic [7:0] A_OTPKEY   = 8'h3f;
   localparam logic [7:0] A_PROT_LO  = 8'h40;
   localparam logic [7:0] A_PROT_HI  = 8'h4f;
   // ----------------------------------------
   // Key values
   // ----------------------------------------
   localparam logic [7:0] K_UNLOCK   = 8'h35;
   localparam logic [7:0] K_REFRESH  = 8'h27;
   localparam logic [7:0] K_RESET    = 8'ha5;
   localparam logic [7:0] K_DBG1     = 8'ha4;
   localparam logic [7:0] K_DBG2     = 8'h25;
   localparam logic [7:0] K_DBG_EXIT = 8'h00;
   localparam logic [7:0] K_OTP_OPEN = 8'h91;
   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int         BAL_W      = 6;
   localparam int         DUR_W      = 6;
   localparam int         ID_W       = 6;
   localparam int         UNIT_BIT   = 7;
   localparam int         ASG_BIT    = 7;
   localparam int         CONVERSION_TRIGGER_BIT   = 0;
   localparam logic [5:0] BCAST_ID   = 6'h3f;
   localparam logic [5:0] F6_RST     = 6'h00;
   localparam logic [7:0] B_RST      = 8'h00;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int         CLK_PERIOD_NS = 8;
   localparam int         TICK_S        = 1;
   localparam int         NS_PER_S      = 1000000000;
   localparam int         SEC_CYCLES    = TICK_S * (NS_PER_S / CLK_PERIOD_NS);
   localparam int         SECS_PER_MIN  = 60;
   localparam int         PRE_W         = 27;
   localparam int         MIN_W         = 6;

   typedef enum logic [1:0] {
      DBG_IDLE  = 2'b00,
      DBG_ARMED = 2'b01,
      DBG_ON    = 2'b11
   } bmcr_dbg_e;
endpackage

// [core/bmcr_tmr_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface bmcr_tmr_if;
   logic       run;
   logic       unit_min;
   logic [5:0] dur;
   logic       expire;

   modport ctl (output run, output unit_min, output dur, input expire);
   modport tmr (input run, input unit_min, input dur, output expire);
endinterface
`default_nettype wire

// [core/bmcr_bal_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module bmcr_bal_timer #(
   parameter int SEC_CYCLES = bmcr_pkg::SEC_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   bmcr_tmr_if.tmr   tif
);
   localparam logic [bmcr_pkg::PRE_W-1:0] PRE_LAST = bmcr_pkg::PRE_W'(SEC_CYCLES - 1);
   localparam logic [bmcr_pkg::MIN_W-1:0] MIN_LAST = bmcr_pkg::MIN_W'(bmcr_pkg::SECS_PER_MIN - 1);

   logic [bmcr_pkg::PRE_W-1:0] pre_ff;
   logic [bmcr_pkg::PRE_W-1:0] nxt_pre;
   logic [bmcr_pkg::MIN_W-1:0] min_ff;
   logic [bmcr_pkg::MIN_W-1:0] nxt_min;
   logic [5:0]                 cnt_ff;
   logic [5:0]                 nxt_cnt;
   logic                       exp_ff;
   logic                       nxt_exp;
   logic                       sec_tick;
   logic                       tick;

   // ----------------------------------------
   // Prescaler and duration count
   // ----------------------------------------
   always_comb begin
      nxt_pre  = pre_ff;
      nxt_min  = min_ff;
      nxt_cnt  = cnt_ff;
      nxt_exp  = 1'b0;
      sec_tick = (pre_ff == PRE_LAST);
      tick     = tif.unit_min ? (sec_tick && (min_ff == MIN_LAST)) : sec_tick;
      // Idle timer restarts from zero, so each burst gets its full span
      if (!tif.run) begin
         nxt_pre = '0;
         nxt_min = '0;
         nxt_cnt = '0;
      end else begin
         nxt_pre = sec_tick ? '0 : pre_ff + 1'b1;
         if (sec_tick) begin
            nxt_min = (min_ff == MIN_LAST) ? '0 : min_ff + 1'b1;
         end
         // (R22) Expiry in unit
         if (tick) begin
            if (({1'b0, cnt_ff} + 7'h01) >= {1'b0, tif.dur}) begin
               nxt_exp = 1'b1;
               nxt_cnt = '0;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pre_ff <= '0;
         min_ff <= '0;
         cnt_ff <= 6'h00;
         exp_ff <= 1'b0;
      end else begin
         pre_ff <= nxt_pre;
         min_ff <= nxt_min;
         cnt_ff <= nxt_cnt;
         exp_ff <= nxt_exp;
      end
   end

   assign tif.expire = exp_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_cnt_bound;
      @(posedge clk) disable iff (rst)
      (tif.run && tick && (({1'b0, cnt_ff} + 7'h01) >= {1'b0, tif.dur})) |=> tif.expire;
   endproperty
   a_cnt_bound: assert property (p_cnt_bound) else $error("balance count passed its limit"); // (R2)

   property p_exp_run;
      @(posedge clk) disable iff (rst)
      tif.expire |-> $past(tif.run) && $past(tick);
   endproperty
   a_exp_run: assert property (p_exp_run) else $error("expiry without a running tick"); // (R22)
endmodule
`default_nettype wire

// [core/bmcr_regs.sv]
// Contract
// (R1) Each balance enable bit drives its balance output; reset low.
// (R2) Balance output active time is capped, zero seconds to 63 minutes.
// (R3) Zero programmed duration keeps every balance output inactive.
// (R4) Timeout bit 7 picks unit: 0 seconds, 1 minutes.
// (R5) Timeout bits 5..0 hold the duration in the chosen unit.
// (R6) Writing 1 to conversion bit 0 starts a conversion; 0 does nothing.
// (R7) Conversion trigger self-clears and always reads 0.
// (R8) Protected writes 0x40..0x4f need prior unlock key 0x35.
// (R9) Unlock reads 0x00, clears on any write, not on reads.
// (R10) Key 0x27 reloads protected registers from OTP; clears when done.
// (R11) Six-bit node id field, 0x00..0x3f, resets to 0x00.
// (R12) Node id 0x3f is broadcast to all assigned devices.
// (R13) Host sets bit 7 after id; mirrored as assigned status, resets 0.
// (R14) Writing 0xa5 to reset key resets device; other values ignored.
// (R15) Debug mode entered after 0xa4 then 0x25 on consecutive writes.
// (R16) Any other register write between key bytes cancels the sequence.
// (R17) Debug mode ends on power-on reset, device reset, or writing 0x00.
// (R18) In debug, clock and data pins output upstream clock and data.
// (R19) Host must never put the lowest stack device in debug.
// (R20) 0x91 opens the OTP write window; host writes only 0x00, 0x91.
// (R21) OTP window closes on next access and after protected write.
// (R22) Balance timer runs while active; expiry clears all enable bits; an A_BAL_CTRL write in the expiry cycle loads its data instead.
// (R23) Reserved bits ignore writes and read as zero.
`timescale 1ns/10ps
`default_nettype none
module bmcr_regs #(
   parameter int SEC_CYCLES = bmcr_pkg::SEC_CYCLES
) (
   input  wire logic       CORE_CLK,
   input  wire logic       SYS_RST,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   output logic      [7:0] REG_RDATA,
   input  wire logic [5:0] FRAME_ADDR,
   output logic            FRAME_HIT,
   output logic            FRAME_BCAST,
   output logic      [5:0] BAL_OUT,
   output logic            CONVERSION_TRIGGER_START,
   output logic            PROT_WR,
   output logic      [7:0] PROT_ADDR,
   output logic      [7:0] PROT_WDATA,
   output logic            REFRESH_REQ,
   input  wire logic       REFRESH_DONE,
   output logic            OTP_WIN,
   output logic            DEV_RESET,
   output logic      [5:0] NODE_ID,
   output logic            ID_ASSIGNED,
   output logic            DEBUG_MODE,
   input  wire logic       UP_SCLK_IN,
   input  wire logic       UP_SDI_IN,
   output logic            SCLK_O,
   output logic            SCLK_OE,
   output logic            SDI_O,
   output logic            SDI_OE
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic                 rst_i;
   logic                 soft_rst_ff;
   logic                 nxt_soft_rst;
   logic [5:0]           bal_en_ff,   nxt_bal_en;
   logic [5:0]           bal_out_ff,  nxt_bal_out;
   logic                 unit_ff,     nxt_unit;
   logic [5:0]           dur_ff,      nxt_dur;
   logic                 conversion_trigger_ff,     nxt_conversion_trigger;
   logic                 unlock_ff,   nxt_unlock;
   logic                 refresh_ff,  nxt_refresh;
   logic                 prot_wr_ff,  nxt_prot_wr;
   logic [7:0]           prot_a_ff,   nxt_prot_a;
   logic [7:0]           prot_d_ff,   nxt_prot_d;
   logic [5:0]           node_ff,     nxt_node;
   logic                 asg_ff,      nxt_asg;
   logic                 hit_ff,      nxt_hit;
   logic                 bcast_ff,    nxt_bcast;
   logic [7:0]           otp_ff,      nxt_otp;
   logic                 win_ff,      nxt_win;
   logic [7:0]           debug_key_byte_ff,     nxt_debug_key_byte;
   bmcr_pkg::bmcr_dbg_e  dbg_ff,      nxt_dbg;
   logic                 sclk_ff,     nxt_sclk;
   logic                 sdi_ff,      nxt_sdi;
   logic                 oe_ff,       nxt_oe;
   logic [7:0]           rdata_ff,    nxt_rdata;
   logic                 prot_range;

   bmcr_tmr_if tif ();

   function automatic logic wr_to(input logic wr, input logic [7:0] a, input logic [7:0] ra);
      return wr && (a == ra);
   endfunction

   // ----------------------------------------
   // Soft reset
   // ----------------------------------------
   // (R14) Reset key
   always_comb begin
      nxt_soft_rst = wr_to(REG_WR, REG_ADDR, bmcr_pkg::A_RSTKEY)
                     && (REG_WDATA == bmcr_pkg::K_RESET) && !soft_rst_ff;
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         soft_rst_ff <= 1'b0;
      end else begin
         soft_rst_ff <= nxt_soft_rst;
      end
   end

   // Whole block restarts one cycle after the key lands
   assign rst_i = SYS_RST | soft_rst_ff;

   // ----------------------------------------
   // Register next state
   // ----------------------------------------
   always_comb begin
      nxt_bal_en  = bal_en_ff;
      nxt_unit    = unit_ff;
      nxt_dur     = dur_ff;
      nxt_unlock  = unlock_ff;
      nxt_refresh = refresh_ff;
      nxt_node    = node_ff;
      nxt_asg     = asg_ff;
      nxt_otp     = otp_ff;
      nxt_debug_key_byte    = debug_key_byte_ff;
      nxt_dbg     = dbg_ff;
      nxt_rdata   = rdata_ff;
      prot_range  = (REG_ADDR >= bmcr_pkg::A_PROT_LO) && (REG_ADDR <= bmcr_pkg::A_PROT_HI);

      // (R22) Expiry clears enables
      if (tif.expire) begin
         nxt_bal_en = '0;
      end
      // (R1) Enable bits
      if (wr_to(REG_WR, REG_ADDR, bmcr_pkg::A_BAL_CTRL)) begin
         nxt_bal_en = REG_WDATA[bmcr_pkg::BAL_W-1:0];
      end
      // (R4) (R5) Unit and duration
      if (wr_to(REG_WR, REG_ADDR, bmcr_pkg::A_BAL_TMO)) begin
         nxt_unit = REG_WDATA[bmcr_pkg::UNIT_BIT];
         nxt_dur  = REG_WDATA[bmcr_pkg::DUR_W-1:0];
      end
      // (R6) (R7) Trigger as pulse
      nxt_conversion_trigger = wr_to(REG_WR, REG_ADDR, bmcr_pkg::A_CONVERSION_TRIGGER) && REG_WDATA[bmcr_pkg::CONVERSION_TRIGGER_BIT];

      // (R8) Gated protected write
      nxt_prot_wr = REG_WR && prot_range && unlock_ff;
      nxt_prot_a  = nxt_prot_wr ? REG_ADDR : prot_a_ff;
      nxt_prot_d  = nxt_prot_wr ? REG_WDATA : prot_d_ff;

      // (R9) Unlock dropped by writes
      if (REG_WR) begin
         nxt_unlock = 1'b0;
      end
      // (R10) Refresh held until done
      if (REFRESH_DONE) begin
         nxt_refresh = 1'b0;
      end
      if (wr_to(REG_WR, REG_ADDR, bmcr_pkg::A_SHADOW_KEY)) begin
         nxt_unlock = (REG_WDATA == bmcr_pkg::K_UNLOCK);
         if (REG_WDATA == bmcr_pkg::K_REFRESH) begin
            nxt_refresh = 1'b1;
         end
      end

      // (R11) (R13) Node id and assigned flag
      if (wr_to(REG_WR, REG_ADDR, bmcr_pkg::A_NODE)) begin
         nxt_node = REG_WDATA[bmcr_pkg::ID_W-1:0];
         nxt_asg  = REG_WDATA[bmcr_pkg::ASG_BIT];
      end
      // (R12) Broadcast match
      if (FRAME_ADDR == bmcr_pkg::BCAST_ID) begin
         nxt_hit   = asg_ff;
         nxt_bcast = asg_ff;
      end else begin
         nxt_hit   = (FRAME_ADDR == node_ff);
         nxt_bcast = 1'b0;
      end

      // (R21) Window closes on any access
      if (REG_WR || REG_RD) begin
         nxt_otp = bmcr_pkg::B_RST;
      end
      // (R20) Window key
      if (wr_to(REG_WR, REG_ADDR, bmcr_pkg::A_OTPKEY)) begin
         nxt_otp = REG_WDATA;
      end
      // Only the exact key opens; other values leave it shut
      nxt_win = (nxt_otp == bmcr_pkg::K_OTP_OPEN);

      if (wr_to(REG_WR, REG_ADDR, bmcr_pkg::A_DBGKEY)) begin
         nxt_debug_key_byte = REG_WDATA;
      end
      // (R15) (R16) (R17) Debug key sequence
      case (dbg_ff)
         bmcr_pkg::DBG_IDLE: begin
            if (wr_to(REG_WR, REG_ADDR, bmcr_pkg::A_DBGKEY) && REG_WDATA == bmcr_pkg::K_DBG1) begin
               nxt_dbg = bmcr_pkg::DBG_ARMED;
            end
         end
         bmcr_pkg::DBG_ARMED: begin
            if (wr_to(REG_WR, REG_ADDR, bmcr_pkg::A_DBGKEY)) begin
               if (REG_WDATA == bmcr_pkg::K_DBG2) begin
                  nxt_dbg = bmcr_pkg::DBG_ON;
               end else if (REG_WDATA != bmcr_pkg::K_DBG1) begin
                  nxt_dbg = bmcr_pkg::DBG_IDLE;
               end
            end else if (REG_WR) begin
               nxt_dbg = bmcr_pkg::DBG_IDLE;
            end
         end
         bmcr_pkg::DBG_ON: begin
            if (wr_to(REG_WR, REG_ADDR, bmcr_pkg::A_DBGKEY) && REG_WDATA == bmcr_pkg::K_DBG_EXIT) begin
               nxt_dbg = bmcr_pkg::DBG_IDLE;
            end
         end
         default: begin
            nxt_dbg = bmcr_pkg::DBG_IDLE;
         end
      endcase
      // (R18) Mirror upstream pins
      nxt_oe   = (dbg_ff == bmcr_pkg::DBG_ON);
      nxt_sclk = nxt_oe && UP_SCLK_IN;
      nxt_sdi  = nxt_oe && UP_SDI_IN;

      // (R3) (R1) Outputs gated by duration
      nxt_bal_out = (dur_ff != bmcr_pkg::F6_RST) ? bal_en_ff : '0;

      // (R23) Read mux, reserved bits zero
      if (REG_RD) begin
         case (REG_ADDR)
            bmcr_pkg::A_BAL_CTRL: nxt_rdata = {2'b00, bal_en_ff};
            bmcr_pkg::A_BAL_TMO:  nxt_rdata = {unit_ff, 1'b0, dur_ff};
            bmcr_pkg::A_NODE:     nxt_rdata = {asg_ff, 1'b0, node_ff};
            bmcr_pkg::A_DBGKEY:   nxt_rdata = debug_key_byte_ff;
            bmcr_pkg::A_OTPKEY:   nxt_rdata = otp_ff;
            default:              nxt_rdata = bmcr_pkg::B_RST;
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (rst_i) begin
         bal_en_ff  <= 6'h00;
         bal_out_ff <= 6'h00;
         unit_ff    <= 1'b0;
         dur_ff     <= 6'h00;
         conversion_trigger_ff    <= 1'b0;
         unlock_ff  <= 1'b0;
         refresh_ff <= 1'b0;
         prot_wr_ff <= 1'b0;
         prot_a_ff  <= 8'h00;
         prot_d_ff  <= 8'h00;
         node_ff    <= 6'h00;
         asg_ff     <= 1'b0;
         hit_ff     <= 1'b0;
         bcast_ff   <= 1'b0;
         otp_ff     <= 8'h00;
         win_ff     <= 1'b0;
         debug_key_byte_ff    <= 8'h00;
         dbg_ff     <= bmcr_pkg::DBG_IDLE;
         sclk_ff    <= 1'b0;
         sdi_ff     <= 1'b0;
         oe_ff      <= 1'b0;
         rdata_ff   <= 8'h00;
      end else begin
         bal_en_ff  <= nxt_bal_en;
         bal_out_ff <= nxt_bal_out;
         unit_ff    <= nxt_unit;
         dur_ff     <= nxt_dur;
         conversion_trigger_ff    <= nxt_conversion_trigger;
         unlock_ff  <= nxt_unlock;
         refresh_ff <= nxt_refresh;
         prot_wr_ff <= nxt_prot_wr;
         prot_a_ff  <= nxt_prot_a;
         prot_d_ff  <= nxt_prot_d;
         node_ff    <= nxt_node;
         asg_ff     <= nxt_asg;
         hit_ff     <= nxt_hit;
         bcast_ff   <= nxt_bcast;
         otp_ff     <= nxt_otp;
         win_ff     <= nxt_win;
         debug_key_byte_ff    <= nxt_debug_key_byte;
         dbg_ff     <= nxt_dbg;
         sclk_ff    <= nxt_sclk;
         sdi_ff     <= nxt_sdi;
         oe_ff      <= nxt_oe;
         rdata_ff   <= nxt_rdata;
      end
   end

   // ----------------------------------------
   // Balance timer
   // ----------------------------------------
   // (R2) (R22) Timer runs on live outputs
   assign tif.run      = (bal_out_ff != 6'h00);
   assign tif.unit_min = unit_ff;
   assign tif.dur      = dur_ff;

   bmcr_bal_timer #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_timer (
      .clk (CORE_CLK),
      .rst (rst_i),
      .tif (tif)
   );

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign REG_RDATA   = rdata_ff;
   assign FRAME_HIT   = hit_ff;
   assign FRAME_BCAST = bcast_ff;
   assign BAL_OUT     = bal_out_ff;
   assign CONVERSION_TRIGGER_START  = conversion_trigger_ff;
   assign PROT_WR     = prot_wr_ff;
   assign PROT_ADDR   = prot_a_ff;
   assign PROT_WDATA  = prot_d_ff;
   assign REFRESH_REQ = refresh_ff;
   assign OTP_WIN     = win_ff;
   assign DEV_RESET   = soft_rst_ff;
   assign NODE_ID     = node_ff;
   assign ID_ASSIGNED = asg_ff;
   assign DEBUG_MODE  = oe_ff;
   assign SCLK_O      = sclk_ff;
   assign SCLK_OE     = oe_ff;
   assign SDI_O       = sdi_ff;
   assign SDI_OE      = oe_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (rst_i);

   sequence s_key1;
      REG_WR && REG_ADDR == bmcr_pkg::A_DBGKEY && REG_WDATA == bmcr_pkg::K_DBG1;
   endsequence
   sequence s_key2;
      REG_WR && REG_ADDR == bmcr_pkg::A_DBGKEY && REG_WDATA == bmcr_pkg::K_DBG2;
   endsequence

   property p_bal_zero;
      (dur_ff == 6'h00) |=> (BAL_OUT == 6'h00);
   endproperty
   a_bal_zero: assert property (p_bal_zero) else $error("balance active with zero duration"); // (R3)

   property p_bal_follow;
      (dur_ff != 6'h00) |=> (BAL_OUT == $past(bal_en_ff));
   endproperty
   a_bal_follow: assert property (p_bal_follow) else $error("balance output not following enable"); // (R1)

   property p_expire_clr;
      (tif.expire && !REG_WR) |=> (bal_en_ff == 6'h00) ##1 (BAL_OUT == 6'h00);
   endproperty
   a_expire_clr: assert property (p_expire_clr) else $error("expiry left balance on"); // (R22)

   property p_conversion_trigger;
      (REG_WR && REG_ADDR == bmcr_pkg::A_CONVERSION_TRIGGER) |=> (CONVERSION_TRIGGER_START == $past(REG_WDATA[0])) ##1 !CONVERSION_TRIGGER_START;
   endproperty
   a_conversion_trigger: assert property (p_conversion_trigger) else $error("conversion start not a single pulse"); // (R6)

   property p_locked;
      (REG_WR && prot_range && !unlock_ff) |=> !PROT_WR;
   endproperty
   a_locked: assert property (p_locked) else $error("protected write passed while locked"); // (R8)

   property p_unlock_clr;
      (REG_WR && REG_ADDR != bmcr_pkg::A_SHADOW_KEY) |=> !unlock_ff;
   endproperty
   a_unlock_clr: assert property (p_unlock_clr) else $error("unlock survived a write"); // (R9)

   property p_dbg_enter;
      s_key1 ##1 s_key2 |=> (DEBUG_MODE == 1'b0) ##1 (SCLK_OE && SDI_OE);
   endproperty
   a_dbg_enter: assert property (p_dbg_enter) else $error("debug key sequence not honoured"); // (R15)

   property p_dbg_cancel;
      (dbg_ff == bmcr_pkg::DBG_ARMED && REG_WR && REG_ADDR != bmcr_pkg::A_DBGKEY)
         |=> (dbg_ff == bmcr_pkg::DBG_IDLE) [*2];
   endproperty
   a_dbg_cancel: assert property (p_dbg_cancel) else $error("partial debug key not voided"); // (R16)

   property p_dbg_mirror;
      (dbg_ff == bmcr_pkg::DBG_ON) |=> (SCLK_O == $past(UP_SCLK_IN)) && (SDI_O == $past(UP_SDI_IN));
   endproperty
   a_dbg_mirror: assert property (p_dbg_mirror) else $error("debug pins not mirroring upstream"); // (R18)

   property p_otp_close;
      (OTP_WIN && (REG_RD || (REG_WR && !(REG_ADDR == bmcr_pkg::A_OTPKEY && REG_WDATA == bmcr_pkg::K_OTP_OPEN))))
         |=> !OTP_WIN;
   endproperty
   a_otp_close: assert property (p_otp_close) else $error("OTP window stayed open"); // (R21)

   property p_soft_rst;
      @(posedge CORE_CLK) disable iff (SYS_RST)
      nxt_soft_rst |=> DEV_RESET ##1 (!DEBUG_MODE && BAL_OUT == 6'h00 && !DEV_RESET);
   endproperty
   a_soft_rst: assert property (p_soft_rst) else $error("reset key did not reset"); // (R14)
endmodule
`default_nettype wire

// [sim/bmcr_otp_model.sv]
`timescale 1ns/10ps
`default_nettype none
module bmcr_otp_model #(
   parameter int DELAY = 4
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic refresh_req,
   output logic      refresh_done,
   output logic      up_sclk,
   output logic      up_sdi
);
   logic [3:0] cnt;
   logic [2:0] pat;
   always_ff @(posedge clk) begin
      if (rst || !refresh_req || refresh_done) begin
         cnt <= 4'h0;
         refresh_done <= 1'b0;
      end else begin
         cnt <= cnt + 4'h1;
         refresh_done <= (cnt == DELAY[3:0]);
      end
   end
   // Upstream pins never idle, so a stale copy shows
   always_ff @(posedge clk) begin
      pat <= rst ? 3'h0 : pat + 3'h1;
      up_sclk <= pat[0];
      up_sdi <= pat[1] ^ pat[2];
   end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wd = 8'h00;
   logic [5:0] frame = 6'h00;
   logic [7:0] rdata, paddr, pwd;
   logic [5:0] bal, node;
   logic       hit, bc, conversion_trigger, pwr, rreq, rdone, otp, dres, asg, dbg;
   logic       usclk, usdi, sclk, sclk_oe, sdi, sdi_oe, sdi_q, sclk_q;
   int         n_errors = 0;
   int         checked = 0;
   always #4 clk = ~clk;
   always @(posedge clk) {sdi_q, sclk_q} <= {usdi, usclk};
   bmcr_regs #(.SEC_CYCLES(10)) u_bmcr_regs (.CORE_CLK(clk), .SYS_RST(rst), .REG_WR(wr), .REG_RD(rd),
      .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rdata), .FRAME_ADDR(frame), .FRAME_HIT(hit),
      .FRAME_BCAST(bc), .BAL_OUT(bal), .CONVERSION_TRIGGER_START(conversion_trigger), .PROT_WR(pwr), .PROT_ADDR(paddr),
      .PROT_WDATA(pwd), .REFRESH_REQ(rreq), .REFRESH_DONE(rdone), .OTP_WIN(otp), .DEV_RESET(dres),
      .NODE_ID(node), .ID_ASSIGNED(asg), .DEBUG_MODE(dbg), .UP_SCLK_IN(usclk), .UP_SDI_IN(usdi),
      .SCLK_O(sclk), .SCLK_OE(sclk_oe), .SDI_O(sdi), .SDI_OE(sdi_oe));
   bmcr_otp_model u_bmcr_otp_model (.clk(clk), .rst(rst), .refresh_req(rreq), .refresh_done(rdone),
      .up_sclk(usclk), .up_sdi(usdi));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   // Two writes on adjacent edges, no idle cycle between them
   task automatic wr2(input logic [7:0] a, input logic [7:0] d1, input logic [7:0] d2);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d1;
      @(posedge clk);
      wd <= d2;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic t_reset();
      chk({asg, 1'b0, node}, 8'h00);
      chk({2'b00, bal}, 8'h00);
      rdc(8'h3b, 8'h00);
      rdc(8'h3a, 8'h00);
   endtask
   task automatic t_bal();
      wrt(8'h33, 8'h42);
      rdc(8'h33, 8'h02);
      wrt(8'h32, 8'hff);
      tick(1);
      chk({2'b00, bal}, 8'h3f);
      tick(15);
      chk({2'b00, bal}, 8'h3f);
      tick(10);
      chk({2'b00, bal}, 8'h00);
      wrt(8'h33, 8'h00);
      wrt(8'h32, 8'h01);
      tick(3);
      chk({2'b00, bal}, 8'h00);
      // Minute unit: seconds would expire near 12 cycles
      wrt(8'h33, 8'h81);
      tick(30);
      chk({2'b00, bal}, 8'h01);
      tick(600);
      chk({2'b00, bal}, 8'h00);
   endtask
   task automatic t_conversion_trigger();
      wrt(8'h34, 8'h01);
      chk(conversion_trigger, 1'b1);
      tick(1);
      chk(conversion_trigger, 1'b0);
      wrt(8'h34, 8'h00);
      chk(conversion_trigger, 1'b0);
      rdc(8'h34, 8'h00);
   endtask
   task automatic t_prot();
      wrt(8'h41, 8'h55);
      chk(pwr, 1'b0);
      wrt(8'h3a, 8'h35);
      wrt(8'h4f, 8'h66);
      chk({pwr, paddr, pwd}, {1'b1, 8'h4f, 8'h66});
      wrt(8'h3a, 8'h35);
      rdc(8'h3a, 8'h00);
      wrt(8'h40, 8'h11);
      chk(pwr, 1'b1);
      wrt(8'h3a, 8'h35);
      wrt(8'h34, 8'h00);
      wrt(8'h43, 8'h22);
      chk(pwr, 1'b0);
      wrt(8'h3a, 8'h27);
      chk(rreq, 1'b1);
      tick(10);
      chk(rreq, 1'b0);
   endtask
   task automatic t_node();
      wrt(8'h3b, 8'h05);
      @(posedge clk);
      frame <= 6'h3f;
      tick(1);
      chk({hit, bc}, 2'b00);
      wrt(8'h3b, 8'hc5);
      chk({asg, node}, 7'h45);
      rdc(8'h3b, 8'h85);
      tick(1);
      chk({hit, bc}, 2'b11);
      @(posedge clk);
      frame <= 6'h05;
      tick(1);
      chk({hit, bc}, 2'b10);
   endtask
   task automatic t_dbg();
      wrt(8'h3d, 8'ha4);
      wrt(8'h34, 8'h00);
      wrt(8'h3d, 8'h25);
      tick(1);
      chk(dbg, 1'b0);
      // Bench device stands mid-string, never the lowest
      wr2(8'h3d, 8'ha4, 8'h25);
      tick(1);
      chk({dbg, sclk_oe, sdi_oe}, 3'h7);
      repeat (4) begin
         tick(1);
         chk({sdi, sclk}, {sdi_q, sclk_q});
      end
      wrt(8'h3d, 8'h00);
      tick(1);
      chk({dbg, sclk_oe, sdi_oe}, 3'h0);
   endtask
   task automatic t_otp_rst();
      wrt(8'h3f, 8'h91);
      chk(otp, 1'b1);
      rdc(8'h3d, 8'h00);
      chk(otp, 1'b0);
      wrt(8'h3c, 8'h5a);
      chk({dres, node}, 7'h05);
      wrt(8'h3d, 8'ha4);
      wrt(8'h3d, 8'h25);
      wrt(8'h3c, 8'ha5);
      chk(dres, 1'b1);
      tick(1);
      chk({dbg, asg, node}, 8'h00);
   endtask
   task automatic stop_test();
      if (n_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      t_reset();
      t_bal();
      t_conversion_trigger();
      t_prot();
      t_node();
      t_dbg();
      t_otp_rst();
      stop_test();
   end
   // Whole run is near 780 cycles
   initial begin
      #200000;
      n_errors++;
      stop_test();
   end
endmodule
`default_nettype wire
